// File: include/tmr_map.svh
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
// ----------------------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------------
`define TMR_CTRL1_OFS      8'h00
`define TMR_CTRL2_OFS      8'h04
`define TMR_STATUS_OFS     8'h08
`define TMR_CAP1_HI_OFS    8'h0C
`define TMR_CAP1_LO_OFS    8'h10
`define TMR_CAP2_HI_OFS    8'h14
`define TMR_CAP2_LO_OFS    8'h18
`define TMR_CMP1_HI_OFS    8'h1C
`define TMR_CMP1_LO_OFS    8'h20
`define TMR_CMP2_HI_OFS    8'h24
`define TMR_CMP2_LO_OFS    8'h28
`define TMR_CNT_HI_OFS     8'h2C
`define TMR_CNT_LO_OFS     8'h30
`define TMR_POWER_OFS      8'h34
// ----------------------------------------------------------------------------
// control one fields
// ----------------------------------------------------------------------------
`define TMR_C1_CAP_IE      7
`define TMR_C1_CMP_IE      6
`define TMR_C1_PULSE_LVL   2
`define TMR_C1_TRIG_EDGE   1
`define TMR_C1_AFTER_LVL   0
// ----------------------------------------------------------------------------
// control two fields
// ----------------------------------------------------------------------------
`define TMR_C2_PIN_EN      7
`define TMR_C2_SINGLE      5
`define TMR_C2_PWM         4
`define TMR_C2_TICK_HI     3
`define TMR_C2_TICK_LO     2
`define TMR_C2_CAP2_EDGE   1
// ----------------------------------------------------------------------------
// status fields, reset values and other constants
// ----------------------------------------------------------------------------
`define TMR_ST_CAP1        7
`define TMR_ST_CMP1        6
`define TMR_ST_CAP2        4
`define TMR_ST_CMP2        3
`define TMR_CMP_RESET      16'h8000
`define TMR_CNT_RESET      16'hFFFC
`define TMR_TRIG_CAPTURE   16'hFFFD
`define TMR_COMPARE_BIAS   5
`define TMR_DIV2_MAX       2'h1
`define TMR_DIV4_MAX       2'h3
`define TMR_DIV8_MAX       3'h7
`endif

// File: include/tmr_pkg.sv
package tmr_pkg;
  // tick source encodings
  typedef enum logic [1:0] {
    TMR_TICK_DIV4 = 2'h0,
    TMR_TICK_DIV2 = 2'h1,
    TMR_TICK_DIV8 = 2'h2,
    TMR_TICK_EXT  = 2'h3
  } tmr_tick_t;

  // operating mode, one-hot
  typedef enum logic [2:0] {
    TMR_MODE_FREE   = 3'h1,
    TMR_MODE_SINGLE = 3'h2,
    TMR_MODE_PWM    = 3'h4
  } tmr_mode_t;

  // avalon slave request
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } tmr_bus_req_t;

  // pin group
  typedef struct packed {
    logic trigger_input_pin;
    logic capture_two_input_pin;
    logic ext_clock_pin;
  } tmr_pins_t;

  // whole module state
  typedef struct packed {
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic        cap1_flag;
    logic        cap2_flag;
    logic        cmp1_flag;
    logic        cmp2_flag;
    logic        cap1_armed;
    logic        cap2_armed;
    logic        cmp1_armed;
    logic        cmp2_armed;
    logic        cap1_inhibit;
    logic        cap2_inhibit;
    logic        cmp1_inhibit;
    logic        cmp2_inhibit;
    logic [15:0] counter;
    logic [15:0] capture_one_value;
    logic [15:0] capture_two_value;
    logic [15:0] compare_one_value;
    logic [15:0] compare_two_value;
    logic [15:0] cmp1_active;
    logic [15:0] cmp2_active;
    logic [7:0]  cap1_lo_latch;
    logic [7:0]  cap2_lo_latch;
    logic [2:0]  prescale;
    logic        trig_prev;
    logic        cap2_prev;
    logic        ext_prev;
    logic        halt_cap1;
    logic        halt_cap2;
    logic        halted;
    logic        wave;
    logic        wave_oe;
    logic        irq;
    logic        wake;
    logic        waitrequest;
    logic [31:0] readdata;
  } tmr_state_t;
endpackage

// File: src/tmr_core.sv
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "tmr_map.svh"

// What this block does
// - single pulse: trigger edge loads FFFC, pulse level, capture FFFD
// - trigger flag raises irq when capture enabled
// - flag clears after status read then low access; compare flags need a low write
// - single pulse match drives after-match level
// - single pulse: no compare one flag, two works
// - both mode bits set means pwm only
// - equal levels give constant waveform
// - single pulse: input two captures, trigger resets
// - compare two flags time, no waveform
// - reduced instance forces second channel off; pwm still reloads on compare two
// - pwm compare two match reloads FFFC
// - pwm matches drive level one and two
// - pwm compare values double buffered per period
// - high pulse spans compare two minus one
// - high byte write inhibits compare until low
// - pwm sets no compare flags
// - pwm period end sets capture one flag
// - pwm trigger disconnected, input two captures
// - wait mode leaves timer running, irq wakes
// - halt freezes counter, resumes, reset restarts
// - halt edge arms capture, taken at exit
// - trigger edge select chooses rising or falling
// - pin enable routes waveform to pin
// - tick select picks divider or external clock
module tmr_core
  import tmr_pkg::*;
#(
  parameter bit REDUCED  = 1'b0,
  parameter bit HAS_EXT  = 1'b1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire tmr_bus_req_t bus,
  input  wire tmr_pins_t    pins,
  input  wire logic         halt_mode,
  input  wire logic         wait_mode,
  output logic              waitrequest,
  output logic [31:0]       readdata,
  output logic              waveform_output_pin,
  output logic              waveform_pin_enable,
  output logic              timer_irq,
  output logic              wake_request
);

  tmr_state_t s_q;
  tmr_state_t s_d;

  // ----------------------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------------------
  tmr_mode_t   mode;
  tmr_tick_t   tsel;
  logic        tick;
  logic        trig_edge;
  logic        cap2_edge;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        st_read;
  logic        cmp1_hit;
  logic        cmp2_hit;
  logic [15:0] cnt_next;
  logic        irq_next;
  logic [3:0]  flag_set;

  assign acc = bus.read | bus.write;
  // single-cycle accept: answer the cycle after the request shows up
  assign wr  = bus.write & s_q.waitrequest;
  assign rd  = bus.read & s_q.waitrequest;

  always_comb begin
    // pwm beats single pulse
    if (s_q.ctrl2[`TMR_C2_PWM])
      mode = TMR_MODE_PWM;
    else if (s_q.ctrl2[`TMR_C2_SINGLE])
      mode = TMR_MODE_SINGLE;
    else
      mode = TMR_MODE_FREE;
  end

  always_comb begin
    tsel = tmr_tick_t'(s_q.ctrl2[`TMR_C2_TICK_HI:`TMR_C2_TICK_LO]);
    // divider ticks; external without a pin never ticks, so the counter stops
    unique case (tsel)
      TMR_TICK_DIV4: tick = (s_q.prescale[1:0] == `TMR_DIV4_MAX);
      TMR_TICK_DIV2: tick = (s_q.prescale[0] == 1'b1);
      TMR_TICK_DIV8: tick = (s_q.prescale == `TMR_DIV8_MAX);
      TMR_TICK_EXT:  tick = HAS_EXT & pins.ext_clock_pin & ~s_q.ext_prev;
    endcase
    if (halt_mode)
      tick = 1'b0;
  end

  // edge detection on pins (pins are synchronous by convention)
  always_comb begin
    if (s_q.ctrl1[`TMR_C1_TRIG_EDGE])
      trig_edge = pins.trigger_input_pin & ~s_q.trig_prev;
    else
      trig_edge = ~pins.trigger_input_pin & s_q.trig_prev;
    if (s_q.ctrl2[`TMR_C2_CAP2_EDGE])
      cap2_edge = pins.capture_two_input_pin & ~s_q.cap2_prev;
    else
      cap2_edge = ~pins.capture_two_input_pin & s_q.cap2_prev;
    if (REDUCED)
      cap2_edge = 1'b0;
  end

  // compares act only on a tick and when not inhibited by a half write
  assign cmp1_hit = tick & ~s_q.cmp1_inhibit & (s_q.counter == s_q.cmp1_active);
  assign cmp2_hit = tick & ~s_q.cmp2_inhibit & (s_q.counter == s_q.cmp2_active);
  assign st_read  = rd & (bus.address == `TMR_STATUS_OFS);
  assign cnt_next = s_q.counter + 16'h0001;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    irq_next = 1'b0;
    // flags start clear so that an event in this cycle shows up in flag_set
    s_d.cap1_flag = 1'b0;
    s_d.cap2_flag = 1'b0;
    s_d.cmp1_flag = 1'b0;
    s_d.cmp2_flag = 1'b0;
    s_d.trig_prev = pins.trigger_input_pin;
    s_d.cap2_prev = pins.capture_two_input_pin;
    s_d.ext_prev  = pins.ext_clock_pin;
    s_d.halted    = halt_mode;
    if (!halt_mode)
      s_d.prescale = s_q.prescale + 3'h1;
    // counter runs through wait untouched
    if (tick)
      s_d.counter = cnt_next;

    // free-running compare mode (plain compare follows, kept short)
    if (mode == TMR_MODE_FREE) begin
      if (cmp1_hit) begin
        s_d.cmp1_flag = 1'b1;
        s_d.wave = s_q.ctrl1[`TMR_C1_AFTER_LVL];
      end
      if (cmp2_hit && !REDUCED)
        s_d.cmp2_flag = 1'b1;
      if (trig_edge && !s_q.cap1_inhibit) begin
        s_d.cap1_flag = 1'b1;
        s_d.capture_one_value = s_q.counter;
      end
    end

    // single pulse
    if (mode == TMR_MODE_SINGLE) begin
      if (cmp1_hit)
        s_d.wave = s_q.ctrl1[`TMR_C1_AFTER_LVL];
      if (cmp2_hit && !REDUCED)
        s_d.cmp2_flag = 1'b1;
      if (trig_edge) begin
        s_d.counter = `TMR_CNT_RESET;
        s_d.wave = s_q.ctrl1[`TMR_C1_PULSE_LVL];
        s_d.cap1_flag = 1'b1;
        s_d.capture_one_value = `TMR_TRIG_CAPTURE;
      end
    end

    // pwm: trigger pin ignored, no compare flags
    if (mode == TMR_MODE_PWM) begin
      if (cmp1_hit)
        s_d.wave = s_q.ctrl1[`TMR_C1_AFTER_LVL];
      if (cmp2_hit) begin
        s_d.wave = s_q.ctrl1[`TMR_C1_PULSE_LVL];
        s_d.counter = `TMR_CNT_RESET;
        s_d.cap1_flag = 1'b1;
        s_d.cmp1_active = s_q.compare_one_value;
        s_d.cmp2_active = s_q.compare_two_value;
      end
    end else begin
      s_d.cmp1_active = s_q.compare_one_value;
      s_d.cmp2_active = s_q.compare_two_value;
    end

    // second capture works in every mode unless reduced
    if (cap2_edge && !s_q.cap2_inhibit) begin
      s_d.cap2_flag = 1'b1;
      s_d.capture_two_value = s_q.counter;
    end

    // halt: remember edges, capture at exit with counter then present
    if (halt_mode) begin
      if (trig_edge && mode == TMR_MODE_FREE)
        s_d.halt_cap1 = 1'b1;
      if (cap2_edge)
        s_d.halt_cap2 = 1'b1;
      s_d.cap1_flag = 1'b0; // no new set while frozen, old flags folded back below
      s_d.cap2_flag = 1'b0;
      s_d.capture_one_value = s_q.capture_one_value;
      s_d.capture_two_value = s_q.capture_two_value;
      s_d.counter = s_q.counter;
      s_d.wave = s_q.wave;
    end else if (s_q.halted) begin
      if (s_q.halt_cap1) begin
        s_d.cap1_flag = 1'b1;
        s_d.capture_one_value = s_q.counter;
      end
      if (s_q.halt_cap2) begin
        s_d.cap2_flag = 1'b1;
        s_d.capture_two_value = s_q.counter;
      end
      s_d.halt_cap1 = 1'b0;
      s_d.halt_cap2 = 1'b0;
    end

    // remember this cycle's sets, then fold the old flags back in
    flag_set = {s_d.cap1_flag, s_d.cap2_flag, s_d.cmp1_flag, s_d.cmp2_flag};
    s_d.cap1_flag = s_d.cap1_flag | s_q.cap1_flag;
    s_d.cap2_flag = s_d.cap2_flag | s_q.cap2_flag;
    s_d.cmp1_flag = s_d.cmp1_flag | s_q.cmp1_flag;
    s_d.cmp2_flag = s_d.cmp2_flag | s_q.cmp2_flag;

    // status read arms the flags that are set at that moment
    if (st_read) begin
      s_d.cap1_armed = s_q.cap1_flag;
      s_d.cap2_armed = s_q.cap2_flag;
      s_d.cmp1_armed = s_q.cmp1_flag;
      s_d.cmp2_armed = s_q.cmp2_flag;
    end

    // bus accesses; clears lose to a set in the same cycle
    s_d.waitrequest = ~(acc & s_q.waitrequest);
    s_d.readdata = 32'h0000_0000;
    if (wr) begin
      unique case (bus.address)
        `TMR_CTRL1_OFS: s_d.ctrl1 = bus.writedata[7:0];
        `TMR_CTRL2_OFS: s_d.ctrl2 = bus.writedata[7:0];
        `TMR_CMP1_HI_OFS: begin
          s_d.compare_one_value[15:8] = bus.writedata[7:0];
          s_d.cmp1_inhibit = 1'b1;
        end
        `TMR_CMP1_LO_OFS: begin
          s_d.compare_one_value[7:0] = bus.writedata[7:0];
          s_d.cmp1_inhibit = 1'b0;
          if (s_q.cmp1_armed && !flag_set[1])
            s_d.cmp1_flag = 1'b0;
          s_d.cmp1_armed = 1'b0;
        end
        `TMR_CMP2_HI_OFS: begin
          s_d.compare_two_value[15:8] = bus.writedata[7:0];
          s_d.cmp2_inhibit = 1'b1;
        end
        `TMR_CMP2_LO_OFS: begin
          s_d.compare_two_value[7:0] = bus.writedata[7:0];
          s_d.cmp2_inhibit = 1'b0;
          if (s_q.cmp2_armed && !flag_set[0])
            s_d.cmp2_flag = 1'b0;
          s_d.cmp2_armed = 1'b0;
        end
        `TMR_CAP1_LO_OFS: begin
          if (s_q.cap1_armed && !flag_set[3])
            s_d.cap1_flag = 1'b0;
          s_d.cap1_armed = 1'b0;
        end
        `TMR_CAP2_LO_OFS: begin
          if (s_q.cap2_armed && !flag_set[2])
            s_d.cap2_flag = 1'b0;
          s_d.cap2_armed = 1'b0;
        end
        default: ;
      endcase
    end
    if (rd) begin
      unique case (bus.address)
        `TMR_CTRL1_OFS:  s_d.readdata = {24'h000000, s_q.ctrl1};
        `TMR_CTRL2_OFS:  s_d.readdata = {24'h000000, s_q.ctrl2};
        `TMR_STATUS_OFS: s_d.readdata = {24'h000000, s_q.cap1_flag, s_q.cmp1_flag, 1'b0,
                                         s_q.cap2_flag, s_q.cmp2_flag, 3'h0};
        `TMR_CAP1_HI_OFS: begin
          s_d.readdata = {24'h000000, s_q.capture_one_value[15:8]};
          s_d.cap1_lo_latch = s_q.capture_one_value[7:0];
          s_d.cap1_inhibit = 1'b1;
        end
        `TMR_CAP1_LO_OFS: begin
          s_d.readdata = {24'h000000, s_q.cap1_inhibit ? s_q.cap1_lo_latch : s_q.capture_one_value[7:0]};
          s_d.cap1_inhibit = 1'b0;
          if (s_q.cap1_armed && !flag_set[3])
            s_d.cap1_flag = 1'b0;
          s_d.cap1_armed = 1'b0;
        end
        `TMR_CAP2_HI_OFS: begin
          s_d.readdata = REDUCED ? 32'h0000_0000 : {24'h000000, s_q.capture_two_value[15:8]};
          s_d.cap2_lo_latch = s_q.capture_two_value[7:0];
          s_d.cap2_inhibit = ~REDUCED;
        end
        `TMR_CAP2_LO_OFS: begin
          s_d.readdata = REDUCED ? 32'h0000_0000 :
                         {24'h000000, s_q.cap2_inhibit ? s_q.cap2_lo_latch : s_q.capture_two_value[7:0]};
          s_d.cap2_inhibit = 1'b0;
          if (s_q.cap2_armed && !flag_set[2])
            s_d.cap2_flag = 1'b0;
          s_d.cap2_armed = 1'b0;
        end
        `TMR_CMP1_HI_OFS: s_d.readdata = {24'h000000, s_q.compare_one_value[15:8]};
        `TMR_CMP1_LO_OFS: s_d.readdata = {24'h000000, s_q.compare_one_value[7:0]};
        // reduced instance: compare two is write-only, reads give zero
        `TMR_CMP2_HI_OFS: s_d.readdata = REDUCED ? 32'h0000_0000 : {24'h000000, s_q.compare_two_value[15:8]};
        `TMR_CMP2_LO_OFS: s_d.readdata = REDUCED ? 32'h0000_0000 : {24'h000000, s_q.compare_two_value[7:0]};
        `TMR_CNT_HI_OFS:  s_d.readdata = {24'h000000, s_q.counter[15:8]};
        `TMR_CNT_LO_OFS:  s_d.readdata = {24'h000000, s_q.counter[7:0]};
        `TMR_POWER_OFS:   s_d.readdata = {30'h0000_0000, s_q.halted, wait_mode};
        default:          s_d.readdata = 32'h0000_0000;
      endcase
    end

    // reduced instance keeps the second channel flags and capture value dead
    if (REDUCED) begin
      s_d.cap2_flag = 1'b0;
      s_d.cmp2_flag = 1'b0;
      s_d.capture_two_value = 16'h0000;
    end

    // interrupt request; also serves as wake from wait
    irq_next = (s_d.ctrl1[`TMR_C1_CAP_IE] & (s_d.cap1_flag | s_d.cap2_flag)) |
               (s_d.ctrl1[`TMR_C1_CMP_IE] & (s_d.cmp1_flag | s_d.cmp2_flag));
    s_d.irq  = irq_next;
    s_d.wake = irq_next & wait_mode;
    s_d.wave_oe = s_d.ctrl2[`TMR_C2_PIN_EN];
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
      s_q.counter <= `TMR_CNT_RESET;
      s_q.compare_one_value <= `TMR_CMP_RESET;
      s_q.compare_two_value <= `TMR_CMP_RESET;
      s_q.cmp1_active <= `TMR_CMP_RESET;
      s_q.cmp2_active <= `TMR_CMP_RESET;
      s_q.waitrequest <= 1'b1;
      // idle-low pins give no false edge after reset; falling edges are selected at reset, so an idle-high pin shows none either
      s_q.trig_prev <= 1'b0;
      s_q.cap2_prev <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign waitrequest         = s_q.waitrequest;
  assign readdata            = s_q.readdata;
  assign waveform_output_pin = s_q.wave;
  assign waveform_pin_enable = s_q.wave_oe;
  assign timer_irq           = s_q.irq;
  assign wake_request        = s_q.wake;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  chk_trig_reload: assert property (@(posedge clock) disable iff (rst)
    (mode == TMR_MODE_SINGLE && trig_edge && !halt_mode) |=> (s_q.counter == 16'hFFFC && s_q.cap1_flag &&
    s_q.capture_one_value == 16'hFFFD)) else $error("trigger reload wrong");
  chk_pwm_reload: assert property (@(posedge clock) disable iff (rst)
    (mode == TMR_MODE_PWM && cmp2_hit && !halt_mode) |=> (s_q.counter == 16'hFFFC && s_q.cap1_flag))
    else $error("pwm period reload wrong");
  chk_pwm_noflag: assert property (@(posedge clock) disable iff (rst)
    (mode == TMR_MODE_PWM && !s_q.cmp1_flag) |=> !s_q.cmp1_flag) else $error("pwm set compare flag");
  chk_single_noflag: assert property (@(posedge clock) disable iff (rst)
    (mode == TMR_MODE_SINGLE && !s_q.cmp1_flag && $stable(s_q.ctrl2)) |=> !s_q.cmp1_flag)
    else $error("single pulse set compare one flag");
  chk_halt_hold: assert property (@(posedge clock) disable iff (rst)
    (halt_mode && s_q.halted) |=> $stable(s_q.counter)) else $error("counter moved in halt");
  chk_irq_cap: assert property (@(posedge clock) disable iff (rst)
    (s_q.cap1_flag && s_q.ctrl1[`TMR_C1_CAP_IE]) |-> timer_irq) else $error("capture irq missing");
  chk_reduced_off: assert property (@(posedge clock) disable iff (rst)
    REDUCED |-> (!s_q.cap2_flag && !s_q.cmp2_flag)) else $error("reduced flags set");
  chk_cmp_inhibit: assert property (@(posedge clock) disable iff (rst)
    (s_q.cmp1_inhibit && mode == TMR_MODE_FREE && !s_q.cmp1_flag) |=> !s_q.cmp1_flag)
    else $error("compare active while inhibited");
  chk_bus_answer: assert property (@(posedge clock) disable iff (rst)
    (acc && s_q.waitrequest) |=> !waitrequest) else $error("bus answer late");
  cov_single: cover property (@(posedge clock) disable iff (rst) mode == TMR_MODE_SINGLE && trig_edge);
  cov_pwm: cover property (@(posedge clock) disable iff (rst) mode == TMR_MODE_PWM && cmp2_hit);
  cov_halt: cover property (@(posedge clock) disable iff (rst) s_q.halted && !halt_mode && s_q.halt_cap2);
endmodule

// File: bench/tmr_pin_model.sv
`timescale 1ns/1ps
module tmr_pin_model
  import tmr_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  trig_req,
  output tmr_pins_t  pins
);
  logic [2:0] div_q;
  logic [2:0] hold_q;
  // ----------------------------------------------------------------
  // external pins
  // ----------------------------------------------------------------
  // trigger is held for several cycles so any sampler sees one edge;
  // the external oscillator runs free, as a real crystal would
  always_ff @(posedge clock) begin
    if (rst) begin
      div_q  <= 3'h0;
      hold_q <= 3'h0;
    end else begin
      div_q  <= (div_q == 3'h5) ? 3'h0 : div_q + 3'h1;
      hold_q <= trig_req ? 3'h4 : ((hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0);
    end
  end
  assign pins.trigger_input_pin     = (hold_q != 3'h0);
  assign pins.capture_two_input_pin = hold_q[1]; // one rising and one falling edge on input two per trigger
  assign pins.ext_clock_pin         = div_q[2];
endmodule

// File: bench/timer_one_pulse_pwm_modes_bench.sv
`timescale 1ns/1ps
`include "tmr_map.svh"
module timer_one_pulse_pwm_modes_bench
  import tmr_pkg::*;
;
  logic         clock;
  logic         rst;
  tmr_bus_req_t bus;
  tmr_pins_t    pins;
  logic         halt_mode;
  logic         wait_mode;
  logic         waitrequest;
  logic [31:0]  readdata;
  logic         wave;
  logic         wave_en;
  logic         irq;
  logic         wake;
  logic         trig_req;
  int           n_fail;
  int           total_checks;
  int           n;
  logic [31:0]  held_hi;
  logic [31:0]  held_lo;

  tmr_core #(.REDUCED(1'b0), .HAS_EXT(1'b1)) tmr_core_inst (
    .clock(clock), .rst(rst), .bus(bus), .pins(pins), .halt_mode(halt_mode),
    .wait_mode(wait_mode), .waitrequest(waitrequest), .readdata(readdata),
    .waveform_output_pin(wave), .waveform_pin_enable(wave_en), .timer_irq(irq), .wake_request(wake)
  );
  tmr_pin_model tmr_pin_model_inst (.clock(clock), .rst(rst), .trig_req(trig_req), .pins(pins));

  always #10 clock = ~clock;

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request rises after an edge and is held until waitrequest is seen low
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int i;
    @(posedge clock);
    bus.address   <= a;
    bus.write     <= wr;
    bus.read      <= !wr;
    bus.writedata <= {24'h0, d};
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      check("waitrequest low", 32'h0, {31'h0, waitrequest});
      wrap_up();
    end
    r = readdata;
    bus.read  <= 1'b0;
    bus.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    access(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [31:0] r;
    access(1'b0, a, 8'h00, r);
    check(what, {24'h0, exp}, r);
  endtask

  // high byte first: the compare stays inhibited until the low byte lands
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h04, v[7:0]);
  endtask

  // bounded wait for a waveform level; n plus one is the number of edges spent
  task automatic wait_wave(input logic lvl);
    for (n = 0; n < 400; n++) begin
      @(posedge clock);
      if (wave === lvl) break;
    end
    if (n == 400) begin
      check("waveform level", {31'h0, lvl}, {31'h0, wave});
      wrap_up();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    bus = '0;
    halt_mode = 1'b0;
    wait_mode = 1'b0;
    trig_req = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(`TMR_CMP1_HI_OFS, 8'h80, "compare one high at reset");
    rd(`TMR_CTRL1_OFS, 8'h00, "control one at reset");
    rd(8'hFC, 8'h00, "unmapped read");
    // single pulse: level 1 during, 0 after, rising trigger, tick /2
    wr(`TMR_CTRL1_OFS, 8'h86);
    wr(`TMR_CTRL2_OFS, 8'hA4);
    wr16(`TMR_CMP1_HI_OFS, 16'd40 - 16'd5);
    check("pin enable", 32'h1, {31'h0, wave_en});
    @(posedge clock);
    trig_req <= 1'b1;
    @(posedge clock);
    trig_req <= 1'b0;
    wait_wave(1'b1);
    repeat (3) @(posedge clock);
    check("capture irq", 32'h1, {31'h0, irq});
    rd(`TMR_STATUS_OFS, 8'h90, "status after trigger");
    rd(`TMR_CAP1_HI_OFS, 8'hFF, "capture one high");
    rd(`TMR_CAP1_LO_OFS, 8'hFD, "capture one low");
    rd(`TMR_STATUS_OFS, 8'h10, "status after clear");
    wait_wave(1'b0);
    // pwm with both mode bits: high from compare one to compare two
    wr16(`TMR_CMP1_HI_OFS, 16'h0010);
    wr16(`TMR_CMP2_HI_OFS, 16'h0030);
    @(posedge clock);
    trig_req <= 1'b1;
    @(posedge clock);
    trig_req <= 1'b0;
    wr(`TMR_CTRL1_OFS, 8'h01);
    wr(`TMR_CTRL2_OFS, 8'hB4);
    wait_wave(1'b0);
    wait_wave(1'b1);
    wait_wave(1'b0);
    check("pwm high length", 32'd64, n + 1);
    // new period value lands only after the running period ends
    wr16(`TMR_CMP2_HI_OFS, 16'h0050);
    wait_wave(1'b1);
    wait_wave(1'b0);
    check("pwm high before reload", 32'd64, n + 1);
    wait_wave(1'b1);
    wait_wave(1'b0);
    check("pwm high after reload", 32'd128, n + 1);
    rd(`TMR_STATUS_OFS, 8'h90, "status in pwm");
    // wait mode keeps the timer and lets the enabled request wake
    wait_mode <= 1'b1;
    wr(`TMR_CTRL1_OFS, 8'h81);
    repeat (3) @(posedge clock);
    check("wake request", 32'h1, {31'h0, wake});
    // halt: counter frozen, an input two edge is held until exit
    wr(`TMR_CAP2_LO_OFS, 8'h00);
    rd(`TMR_STATUS_OFS, 8'h80, "status after write clear");
    halt_mode <= 1'b1;
    access(1'b0, `TMR_CNT_HI_OFS, 8'h00, held_hi);
    access(1'b0, `TMR_CNT_LO_OFS, 8'h00, held_lo);
    @(posedge clock);
    trig_req <= 1'b1;
    @(posedge clock);
    trig_req <= 1'b0;
    repeat (8) @(posedge clock);
    rd(`TMR_CNT_LO_OFS, held_lo[7:0], "counter low in halt");
    rd(`TMR_STATUS_OFS, 8'h80, "status in halt");
    halt_mode <= 1'b0;
    rd(`TMR_STATUS_OFS, 8'h90, "status after halt exit");
    rd(`TMR_CAP2_HI_OFS, held_hi[7:0], "capture two high at exit");
    rd(`TMR_CAP2_LO_OFS, held_lo[7:0], "capture two low at exit");
    wrap_up();
  end
endmodule
